// ===== verilog/lts_consts.svh
// constants for the logic tile: sizes and reset values
// assumes inclusion by every tile source file
`ifndef LTS_CONSTS_SVH
`define LTS_CONSTS_SVH
`define LTS_NCELL 4
`define LTS_NSLICE 2
`define LTS_LUT_NIN 4
`define LTS_LUT_DEPTH 16
`define LTS_STORE_RST 2'h0
`define LTS_SHIFT_CHK 5'h10
`endif

// ===== verilog/lts_pkg.sv
// types shared by the logic tile modules
// assumes nothing of its surroundings
package lts_pkg;
  typedef enum logic [1:0] {LTS_LUT_LOGIC, LTS_LUT_RAM, LTS_LUT_SHIFT} lts_lut_mode_t;
  typedef enum logic [1:0] {LTS_RAM_SINGLE, LTS_RAM_16X2, LTS_RAM_32X1, LTS_RAM_DUAL}
    lts_ram_shape_t;
  typedef enum logic [1:0] {LTS_D_LUT, LTS_D_SUM, LTS_D_DIRECT} lts_dsel_t;
  typedef enum logic [1:0] {LTS_CY_ADD, LTS_CY_MULT, LTS_CY_WIDE} lts_carry_mode_t;
endpackage : lts_pkg

// ===== verilog/lts_lut_if.sv
// interface between the tile and one look-up table
// assumes one instance per logic cell
`timescale 1ns/10ps
`default_nettype none
interface lts_lut_if;
  logic [3:0] raddr;
  logic [3:0] waddr;
  logic       we;
  logic       wd;
  logic       rd;
  logic       sh;
  modport lut (input raddr, input waddr, input we, input wd, output rd, output sh);
  modport tile (output raddr, output waddr, output we, output wd, input rd, input sh);
endinterface : lts_lut_if
`default_nettype wire

// ===== verilog/lts_lut.sv
// one 4-input look-up table: function, 16x1 ram or 16-bit shifter
// assumes the tile steers addresses and write strobes through the interface
`timescale 1ns/10ps
`default_nettype none
`include "lts_consts.svh"
module lts_lut
  import lts_pkg::*;
#(
  parameter int DEPTH = `LTS_LUT_DEPTH
) (
  input wire logic             clk_i,
  input wire logic             rst_n_i,
  input wire logic             cfg_load_i,
  input wire logic [DEPTH-1:0] cfg_init_i,
  input wire lts_lut_mode_t    cfg_mode_i,
  lts_lut_if.lut               bus
);
  typedef struct packed {
    logic [DEPTH-1:0] mem;
  } lts_lut_state_t;
  lts_lut_state_t state_r;
  lts_lut_state_t state_nxt;

  // ========
  // table contents
  always_comb begin
    state_nxt = state_r;
    if (cfg_load_i) begin
      state_nxt.mem = cfg_init_i;
    end else if (bus.we) begin
      case (cfg_mode_i)
        LTS_LUT_RAM:   state_nxt.mem[bus.waddr] = bus.wd;
        LTS_LUT_SHIFT: state_nxt.mem = {state_r.mem[DEPTH-2:0], bus.wd};
        default:       state_nxt.mem = state_r.mem;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign bus.rd = state_r.mem[bus.raddr];
  assign bus.sh = state_r.mem[DEPTH-1];
endmodule : lts_lut
`default_nettype wire

// ===== verilog/lts_slice_store.sv
// the two storage elements of one slice with shared controls
// assumes control inputs come from logic on clk_i; slice clock is sampled
`timescale 1ns/10ps
`default_nettype none
`include "lts_consts.svh"
module lts_slice_store
  import lts_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cfg_load_i,
  input wire logic       cfg_latch_i,
  input wire logic [1:0] cfg_init_val_i,
  input wire logic       cfg_async_init_i,
  input wire logic       cfg_async_opp_i,
  input wire logic       cfg_inv_clk_i,
  input wire logic       cfg_inv_ce_i,
  input wire logic       cfg_inv_init_i,
  input wire logic       cfg_inv_opp_i,
  input wire logic       slice_clk_i,
  input wire logic       slice_ce_i,
  input wire logic       init_state_force_i,
  input wire logic       opposite_state_force_i,
  input wire logic [1:0] d_i,
  output logic     [1:0] q_o
);
  typedef struct packed {
    logic       clk_prev;
    logic [1:0] q;
  } lts_store_state_t;
  lts_store_state_t state_r;
  lts_store_state_t state_nxt;
  logic clk_lvl;
  logic ce_act;
  logic init_act;
  logic opp_act;
  logic edge_hit;
  logic capture;

  assign clk_lvl  = slice_clk_i ^ cfg_inv_clk_i;
  assign ce_act   = slice_ce_i ^ cfg_inv_ce_i;
  assign init_act = init_state_force_i ^ cfg_inv_init_i;
  assign opp_act  = opposite_state_force_i ^ cfg_inv_opp_i;
  assign edge_hit = clk_lvl & ~state_r.clk_prev;
  assign capture  = ce_act & (cfg_latch_i ? clk_lvl : edge_hit);

  // ========
  // next state; init force beats opposite force when both act
  always_comb begin
    state_nxt = state_r;
    state_nxt.clk_prev = clk_lvl;
    if (cfg_load_i) begin
      state_nxt.q = cfg_init_val_i;
    end else if (cfg_async_init_i && init_act) begin
      state_nxt.q = cfg_init_val_i;
    end else if (cfg_async_opp_i && opp_act && !init_act) begin
      state_nxt.q = ~cfg_init_val_i;
    end else if (init_act && edge_hit) begin
      state_nxt.q = cfg_init_val_i;
    end else if (opp_act && edge_hit) begin
      state_nxt.q = ~cfg_init_val_i;
    end else if (capture) begin
      state_nxt.q = d_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= {1'b0, `LTS_STORE_RST};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q_o = (cfg_async_init_i && init_act) ? cfg_init_val_i :
               (cfg_async_opp_i && opp_act && !init_act) ? ~cfg_init_val_i : state_r.q;

  // ========
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_sync_init;
    !cfg_load_i && init_act && edge_hit |=> state_r.q == $past(cfg_init_val_i);
  endproperty
  a_sync_init: assert property (p_sync_init) else $error("init force missed");
  property p_opp;
    !cfg_load_i && !init_act && opp_act && edge_hit |=> state_r.q == ~$past(cfg_init_val_i);
  endproperty
  a_opp: assert property (p_opp) else $error("opposite force missed");
  property p_async_init;
    cfg_async_init_i && init_act |-> q_o == cfg_init_val_i;
  endproperty
  a_async_init: assert property (p_async_init) else $error("async init late");
  property p_latch;
    cfg_latch_i && clk_lvl && ce_act && !init_act && !opp_act && !cfg_load_i
      |=> state_r.q == $past(d_i);
  endproperty
  a_latch: assert property (p_latch) else $error("latch not transparent");
  property p_hold;
    !cfg_latch_i && !edge_hit && !init_act && !opp_act && !cfg_load_i |=> $stable(state_r.q);
  endproperty
  a_hold: assert property (p_hold) else $error("flop changed off edge");
endmodule : lts_slice_store
`default_nettype wire

// ===== verilog/lts_logic_tile.sv
// logic tile: two slices of two logic cells, muxes, carry chains
// assumes config inputs are static between loads and all inputs share clk_i
`timescale 1ns/10ps
`default_nettype none
`include "lts_consts.svh"
// Function
// - four logic cells in two slices
// - each generator is a 4-input table
// - table feeds comb output and storage
// - table usable as 16x1 synchronous ram
// - slice tables form 16x2, 32x1, dual-port
// - table usable as 16-bit shift register
// - storage element is flip-flop or latch
// - storage data from table, sum or direct input
// - init force loads configured initial value
// - opposite force loads complemented initial value
// - forces synchronous, optionally asynchronous
// - slice controls invertible, shared by pair
// - per-slice five-input mux picks table
// - six-input mux picks five-input mux output
// - four direct feedthrough paths per tile
// - two carry chains, two bits each
// - xor gate gives full adder per cell
// - and gate for multiplier partial products
// - carry path cascades wide logic
module lts_logic_tile
  import lts_pkg::*;
#(
  parameter int NCELL  = `LTS_NCELL,
  parameter int NSLICE = `LTS_NSLICE,
  parameter int NIN    = `LTS_LUT_NIN,
  parameter int DEPTH  = `LTS_LUT_DEPTH
) (
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   cfg_load_i,
  input wire logic [NCELL*DEPTH-1:0] cfg_lut_init_i,
  input wire lts_lut_mode_t          cfg_lut_mode_i [NCELL],
  input wire lts_ram_shape_t         cfg_ram_shape_i [NSLICE],
  input wire lts_dsel_t              cfg_dsel_i [NCELL],
  input wire lts_carry_mode_t        cfg_carry_mode_i [NSLICE],
  input wire logic [NCELL-1:0]       cfg_init_val_i,
  input wire logic [NSLICE-1:0]      cfg_latch_i,
  input wire logic [NSLICE-1:0]      cfg_async_init_i,
  input wire logic [NSLICE-1:0]      cfg_async_opp_i,
  input wire logic [NSLICE-1:0]      cfg_inv_clk_i,
  input wire logic [NSLICE-1:0]      cfg_inv_ce_i,
  input wire logic [NSLICE-1:0]      cfg_inv_init_i,
  input wire logic [NSLICE-1:0]      cfg_inv_opp_i,
  input wire logic [NCELL*NIN-1:0]   lut_in_i,
  input wire logic [NCELL-1:0]       direct_i,
  input wire logic [NSLICE-1:0]      wr_en_i,
  input wire logic [NCELL-1:0]       wr_data_i,
  input wire logic [NSLICE-1:0]      carry_i,
  input wire logic [NSLICE-1:0]      slice_clk_i,
  input wire logic [NSLICE-1:0]      slice_ce_i,
  input wire logic [NSLICE-1:0]      init_state_force_i,
  input wire logic [NSLICE-1:0]      opposite_state_force_i,
  input wire logic [NSLICE-1:0]      five_sel_i,
  input wire logic                   six_sel_i,
  output logic     [NCELL-1:0]       comb_o,
  output logic     [NCELL-1:0]       sum_o,
  output logic     [NCELL-1:0]       q_o,
  output logic     [NCELL-1:0]       feed_o,
  output logic     [NCELL-1:0]       shift_o,
  output logic     [NSLICE-1:0]      carry_o,
  output logic     [NSLICE-1:0]      five_input_mux_o,
  output logic                       six_input_mux_o
);
  lts_lut_if  lut_bus [NCELL] ();
  logic [NCELL-1:0] lut_out;
  logic [NCELL-1:0] cy_in;
  logic [NCELL-1:0] cy_out;
  logic [NCELL-1:0] gen;
  logic [NCELL-1:0] st_d;

  // ========
  // logic cells
  // four cells, two per slice
  for (genvar g = 0; g < NCELL; g++) begin : g_cell
    localparam int S  = g / 2;
    localparam int HI = g % 2;
    logic [NIN-1:0] own_addr;
    logic [NIN-1:0] base_addr;
    assign own_addr  = lut_in_i[g*NIN +: NIN];
    assign base_addr = lut_in_i[(2*S)*NIN +: NIN];

    always_comb begin
      lut_bus[g].raddr = own_addr;
      lut_bus[g].waddr = own_addr;
      lut_bus[g].we    = wr_en_i[S];
      lut_bus[g].wd    = wr_data_i[g];
      if (cfg_lut_mode_i[g] == LTS_LUT_RAM) begin
        case (cfg_ram_shape_i[S])
          LTS_RAM_16X2: begin
            lut_bus[g].raddr = base_addr;
            lut_bus[g].waddr = base_addr;
          end
          LTS_RAM_32X1: begin
            lut_bus[g].raddr = base_addr;
            lut_bus[g].waddr = base_addr;
            lut_bus[g].wd    = wr_data_i[2*S];
            lut_bus[g].we    = wr_en_i[S] & (five_sel_i[S] == 1'(HI));
          end
          // both cells write at the lower cell's address, upper cell reads its own address
          LTS_RAM_DUAL: begin
            lut_bus[g].waddr = base_addr;
            lut_bus[g].wd    = wr_data_i[2*S];
          end
          default: begin
            lut_bus[g].raddr = own_addr;
          end
        endcase
      end
    end

    lts_lut #(
      .DEPTH      (DEPTH)
    ) u_lut (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .cfg_load_i (cfg_load_i),
      .cfg_init_i (cfg_lut_init_i[g*DEPTH +: DEPTH]),
      .cfg_mode_i (cfg_lut_mode_i[g]),
      .bus        (lut_bus[g])
    );
    assign lut_out[g] = lut_bus[g].rd;
    assign comb_o[g]  = lut_out[g];
    assign shift_o[g] = lut_bus[g].sh;
    assign feed_o[g]  = direct_i[g];

    if (HI == 0) begin : g_lo
      assign cy_in[g] = carry_i[S];
    end else begin : g_hi
      assign cy_in[g] = cy_out[g-1];
    end

    always_comb begin
      case (cfg_carry_mode_i[S])
        LTS_CY_MULT: gen[g] = own_addr[0] & own_addr[1];
        LTS_CY_WIDE: gen[g] = 1'b0;
        default:     gen[g] = own_addr[0];
      endcase
    end
    // table output is the propagate term
    assign cy_out[g] = lut_out[g] ? cy_in[g] : gen[g];
    assign sum_o[g]  = lut_out[g] ^ cy_in[g];

    always_comb begin
      case (cfg_dsel_i[g])
        LTS_D_SUM:    st_d[g] = sum_o[g];
        LTS_D_DIRECT: st_d[g] = direct_i[g];
        default:      st_d[g] = lut_out[g];
      endcase
    end
  end

  // ========
  // slices
  for (genvar s = 0; s < NSLICE; s++) begin : g_slice
    lts_slice_store u_store (
      .clk_i                  (clk_i),
      .rst_n_i                (rst_n_i),
      .cfg_load_i             (cfg_load_i),
      .cfg_latch_i            (cfg_latch_i[s]),
      .cfg_init_val_i         (cfg_init_val_i[2*s +: 2]),
      .cfg_async_init_i       (cfg_async_init_i[s]),
      .cfg_async_opp_i        (cfg_async_opp_i[s]),
      .cfg_inv_clk_i          (cfg_inv_clk_i[s]),
      .cfg_inv_ce_i           (cfg_inv_ce_i[s]),
      .cfg_inv_init_i         (cfg_inv_init_i[s]),
      .cfg_inv_opp_i          (cfg_inv_opp_i[s]),
      .slice_clk_i            (slice_clk_i[s]),
      .slice_ce_i             (slice_ce_i[s]),
      .init_state_force_i     (init_state_force_i[s]),
      .opposite_state_force_i (opposite_state_force_i[s]),
      .d_i                    (st_d[2*s +: 2]),
      .q_o                    (q_o[2*s +: 2])
    );
    assign carry_o[s] = cy_out[2*s+1];
    assign five_input_mux_o[s] = five_sel_i[s] ? lut_out[2*s+1] : lut_out[2*s];
  end

  assign six_input_mux_o = six_sel_i ? five_input_mux_o[1] : five_input_mux_o[0];

  // ========
  // checks
  // shift runs are only checked on cell 2; other cells share the code
  logic [4:0] shift_run_r;
  logic [4:0] shift_run_nxt;
  logic       shift_go;
  logic       ram0;
  logic       deep0;
  logic       ram01;
  logic       pair0;
  logic       dual0;
  assign shift_go = cfg_lut_mode_i[2] == LTS_LUT_SHIFT && wr_en_i[1] && !cfg_load_i;
  assign ram0     = cfg_lut_mode_i[0] == LTS_LUT_RAM
                    && cfg_ram_shape_i[0] == LTS_RAM_SINGLE;
  assign deep0    = cfg_lut_mode_i[0] == LTS_LUT_RAM && cfg_lut_mode_i[1] == LTS_LUT_RAM
                    && cfg_ram_shape_i[0] == LTS_RAM_32X1;
  assign ram01    = cfg_lut_mode_i[0] == LTS_LUT_RAM && cfg_lut_mode_i[1] == LTS_LUT_RAM;
  assign pair0    = ram01 && cfg_ram_shape_i[0] == LTS_RAM_16X2;
  assign dual0    = ram01 && cfg_ram_shape_i[0] == LTS_RAM_DUAL;
  always_comb begin
    shift_run_nxt = 5'h00;
    if (shift_go) begin
      shift_run_nxt = (shift_run_r == `LTS_SHIFT_CHK) ? shift_run_r : 5'(shift_run_r + 5'h01);
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_run_r <= 5'h00;
    end else begin
      shift_run_r <= shift_run_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_logic_fn;
    $past(cfg_load_i) && !cfg_load_i && cfg_lut_mode_i[0] == LTS_LUT_LOGIC
      |-> comb_o[0] == |($past(cfg_lut_init_i[DEPTH-1:0]) & (DEPTH'(1) << lut_in_i[NIN-1:0]));
  endproperty
  a_logic_fn: assert property (p_logic_fn) else $error("table function wrong");

  sequence s_ram_wr;
    ram0 && wr_en_i[0] && !cfg_load_i;
  endsequence
  sequence s_ram_rd;
    ram0 && lut_in_i[NIN-1:0] == $past(lut_in_i[NIN-1:0]);
  endsequence
  property p_ram_rd;
    s_ram_wr ##1 s_ram_rd |-> comb_o[0] == $past(wr_data_i[0]);
  endproperty
  a_ram_rd: assert property (p_ram_rd) else $error("ram readback wrong");

  property p_ram_idle;
    ram0 && !wr_en_i[0] && !cfg_load_i ##1 s_ram_rd |-> $stable(comb_o[0]);
  endproperty
  a_ram_idle: assert property (p_ram_idle) else $error("ram changed without write");

  sequence s_deep_wr;
    deep0 && wr_en_i[0] && five_sel_i[0] && !cfg_load_i;
  endsequence
  property p_deep_rd;
    s_deep_wr ##1 (deep0 && five_sel_i[0] && lut_in_i[NIN-1:0] == $past(lut_in_i[NIN-1:0]))
      |-> five_input_mux_o[0] == $past(wr_data_i[0]);
  endproperty
  a_deep_rd: assert property (p_deep_rd) else $error("32x1 readback wrong");

  property p_shift;
    shift_run_r == `LTS_SHIFT_CHK |-> shift_o[2] == $past(wr_data_i[2], 16);
  endproperty
  a_shift: assert property (p_shift) else $error("shift tap wrong");

  property p_five;
    five_input_mux_o[0] == (five_sel_i[0] ? lut_bus[1].rd : lut_bus[0].rd);
  endproperty
  a_five: assert property (p_five) else $error("five-input mux wrong");

  property p_six;
    six_input_mux_o == (six_sel_i ? comb_o[2 + 32'(five_sel_i[1])]
                                  : comb_o[32'(five_sel_i[0])]);
  endproperty
  a_six: assert property (p_six) else $error("six-input mux wrong");

  property p_feed;
    feed_o == direct_i;
  endproperty
  a_feed: assert property (p_feed) else $error("feedthrough wrong");

  property p_carry_prop;
    &lut_out[1:0] |-> carry_o[0] == carry_i[0];
  endproperty
  a_carry_prop: assert property (p_carry_prop) else $error("carry not propagated");

  property p_sum;
    sum_o[1] == (comb_o[1] ^ (comb_o[0] ? carry_i[0] : gen[0]));
  endproperty
  a_sum: assert property (p_sum) else $error("sum bit wrong");

  property p_mult;
    cfg_carry_mode_i[0] == LTS_CY_MULT && !lut_out[0]
      |-> cy_out[0] == (lut_in_i[0] & lut_in_i[1]);
  endproperty
  a_mult: assert property (p_mult) else $error("partial product wrong");

  property p_wide;
    cfg_carry_mode_i[0] == LTS_CY_WIDE |-> carry_o[0] == (carry_i[0] & lut_out[0] & lut_out[1]);
  endproperty
  a_wide: assert property (p_wide) else $error("wide cascade wrong");

  property p_dsel;
    cfg_dsel_i[0] == LTS_D_DIRECT |-> st_d[0] == direct_i[0];
  endproperty
  a_dsel: assert property (p_dsel) else $error("storage data select wrong");

  sequence s_pair_wr;
    pair0 && wr_en_i[0] && !cfg_load_i;
  endsequence
  property p_pair_rd;
    s_pair_wr ##1 (pair0 && lut_in_i[NIN-1:0] == $past(lut_in_i[NIN-1:0]))
      |-> comb_o[1:0] == $past(wr_data_i[1:0]);
  endproperty
  a_pair_rd: assert property (p_pair_rd) else $error("16x2 readback wrong");

  sequence s_dual_wr;
    dual0 && wr_en_i[0] && !cfg_load_i;
  endsequence
  property p_dual_rd;
    s_dual_wr ##1 (dual0 && lut_in_i[2*NIN-1:NIN] == $past(lut_in_i[NIN-1:0]))
      |-> comb_o[1] == $past(wr_data_i[0]);
  endproperty
  a_dual_rd: assert property (p_dual_rd) else $error("dual-port readback wrong");

  property p_sum_d;
    cfg_dsel_i[0] == LTS_D_SUM |-> st_d[0] == (comb_o[0] ^ carry_i[0]);
  endproperty
  a_sum_d: assert property (p_sum_d) else $error("sum not stored");

  property p_logic_hold;
    cfg_lut_mode_i[1] == LTS_LUT_LOGIC && wr_en_i[0] && !cfg_load_i
      |=> $stable(g_cell[1].u_lut.state_r.mem);
  endproperty
  a_logic_hold: assert property (p_logic_hold) else $error("logic table written");

  property p_carry_gen;
    cfg_carry_mode_i[0] == LTS_CY_ADD && !lut_out[0] |-> cy_out[0] == lut_in_i[0];
  endproperty
  a_carry_gen: assert property (p_carry_gen) else $error("carry generate wrong");
endmodule : lts_logic_tile
`default_nettype wire

// ===== test/lts_route_model.sv
// routing-side model: drives the two slice clocks seen by the tile
// assumes fire_i comes from bench logic on clk_i; one fire cycle gives one active edge
`timescale 1ns/10ps
`default_nettype none
module lts_route_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] fire_i,
  input  wire logic [1:0] inv_i,
  output logic      [1:0] slice_clk_o
);
  logic [1:0] act_r;
  initial act_r = 2'h0;
  // ==========================================
  // slice clock
  // idle level follows inversion
  // the clock stands inactive between pulses, it never runs free
  always @(posedge clk_i) act_r <= fire_i;
  assign slice_clk_o = act_r ^ inv_i;
endmodule : lts_route_model
`default_nettype wire

// ===== test/lts_logic_tile_bench.sv
// self-checking bench for the logic tile
// assumes the routing model drives slice clocks; inputs change 1 ns after clk_i rises
`timescale 1ns/10ps
`default_nettype none
module lts_logic_tile_bench;
  import lts_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [3:0]  d;
    logic [1:0]  ci;
    logic [1:0]  f5;
    logic        f6;
    logic [3:0]  comb;
  } lts_row_t;
  lts_row_t rows [4] = '{
    '{16'h0000, 4'h5, 2'h3, 2'h1, 1'b0, 4'h0},
    '{16'hffff, 4'ha, 2'h1, 2'h2, 1'b1, 4'hb},
    '{16'h1111, 4'h3, 2'h2, 2'h3, 1'b1, 4'he},
    '{16'h7f3e, 4'hc, 2'h0, 2'h0, 1'b0, 4'ha}};
  logic            clk_i, rst_n_i, cfg_load_i, six_sel, six_o, p0, p1, cm;
  logic [63:0]     lut_init;
  lts_lut_mode_t   lut_mode [4];
  lts_ram_shape_t  shape [2];
  lts_dsel_t       dsel [4];
  lts_carry_mode_t cy_mode [2];
  logic [15:0]     lut_in, pat;
  logic [3:0]      init_val, direct, wr_data, comb_o, sum_o, q_o, feed_o, shift_o;
  logic [1:0]      latch, a_init, a_opp, inv_clk, inv_ce, wr_en, carry_in, ce, init_f, opp_f;
  logic [1:0]      five_sel, fire, slice_clk, carry_o, five_o, inv_init, inv_opp;
  int              err_total, comparisons, cycles, j;

  lts_route_model route (.clk_i(clk_i), .fire_i(fire), .inv_i(inv_clk), .slice_clk_o(slice_clk));
  lts_logic_tile dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_load_i(cfg_load_i), .cfg_lut_init_i(lut_init),
    .cfg_lut_mode_i(lut_mode), .cfg_ram_shape_i(shape), .cfg_dsel_i(dsel),
    .cfg_carry_mode_i(cy_mode), .cfg_init_val_i(init_val), .cfg_latch_i(latch),
    .cfg_async_init_i(a_init), .cfg_async_opp_i(a_opp), .cfg_inv_clk_i(inv_clk),
    .cfg_inv_ce_i(inv_ce), .cfg_inv_init_i(inv_init), .cfg_inv_opp_i(inv_opp), .lut_in_i(lut_in),
    .direct_i(direct), .wr_en_i(wr_en), .wr_data_i(wr_data), .carry_i(carry_in),
    .slice_clk_i(slice_clk), .slice_ce_i(ce), .init_state_force_i(init_f),
    .opposite_state_force_i(opp_f), .five_sel_i(five_sel), .six_sel_i(six_sel),
    .comb_o(comb_o), .sum_o(sum_o), .q_o(q_o), .feed_o(feed_o), .shift_o(shift_o),
    .carry_o(carry_o), .five_input_mux_o(five_o), .six_input_mux_o(six_o));

  // ==========================================
  // helpers
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic load;
    cfg_load_i = 1'b1;
    tick(1);
    cfg_load_i = 1'b0;
    tick(1);
  endtask : load
  // one active slice clock edge, then time for the capture to land
  task automatic strobe(input logic [1:0] s);
    fire = s;
    tick(1);
    fire = 2'h0;
    tick(3);
  endtask : strobe
  function automatic logic gen(input lts_carry_mode_t m, input logic [3:0] a);
    return (m == LTS_CY_ADD) ? a[0] : ((m == LTS_CY_MULT) ? (a[0] & a[1]) : 1'b0);
  endfunction : gen
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // a hang is cut short well past the roughly 113 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    rst_n_i = 1'b0; cfg_load_i = 1'b0; lut_init = {16'haaaa, 16'h6996, 16'hfffe, 16'h8000};
    lut_mode = '{default: LTS_LUT_LOGIC}; shape = '{default: LTS_RAM_SINGLE};
    dsel = '{LTS_D_LUT, LTS_D_DIRECT, LTS_D_DIRECT, LTS_D_DIRECT};
    cy_mode = '{default: LTS_CY_ADD}; init_val = 4'h6; latch = 2'h0; a_init = 2'h0;
    a_opp = 2'h0; inv_clk = 2'h0; inv_ce = 2'h0; lut_in = 16'h0; direct = 4'h0;
    wr_en = 2'h0; wr_data = 4'h0; carry_in = 2'h0; ce = 2'h0; init_f = 2'h0; opp_f = 2'h0;
    five_sel = 2'h0; six_sel = 1'b0; fire = 2'h0; err_total = 0; comparisons = 0; cycles = 0;
    inv_init = 2'h0; inv_opp = 2'h0;
    tick(20);
    rst_n_i = 1'b1;
    tick(1);
    for (int k = 0; k < 2; k++) begin
      cy_mode[0] = k ? LTS_CY_WIDE : LTS_CY_ADD;
      cy_mode[1] = k ? LTS_CY_ADD : LTS_CY_MULT;
      load();
      foreach (rows[i]) begin
        lut_in = rows[i].a; direct = rows[i].d; carry_in = rows[i].ci;
        five_sel = rows[i].f5; six_sel = rows[i].f6;
        #1;
        chk(16'(comb_o), 16'(rows[i].comb));
        chk(16'(feed_o), 16'(rows[i].d));
        for (int s = 0; s < 2; s++) begin
          p0 = rows[i].comb[2*s];
          p1 = rows[i].comb[2*s+1];
          cm = p0 ? rows[i].ci[s] : gen(cy_mode[s], rows[i].a[8*s +: 4]);
          chk(16'(sum_o[2*s +: 2]), 16'({p1 ^ cm, p0 ^ rows[i].ci[s]}));
          chk(16'(carry_o[s]), 16'(p1 ? cm : gen(cy_mode[s], rows[i].a[8*s+4 +: 4])));
          chk(16'(five_o[s]), 16'(rows[i].f5[s] ? p1 : p0));
        end
        j = rows[i].f6;
        chk(16'(six_o), 16'(rows[i].comb[2*j + rows[i].f5[j]]));
      end
    end
    $display("test logic rows done");
    // ram on cell 0, logic on cell 1 shares the enable, shifters on slice 1
    lut_mode = '{LTS_LUT_RAM, LTS_LUT_LOGIC, LTS_LUT_SHIFT, LTS_LUT_SHIFT};
    load();
    lut_in = 16'h0055; wr_data = 4'h1;
    tick(1);
    chk(16'(comb_o[1:0]), 16'h2);
    wr_en = 2'h1;
    tick(1);
    wr_en = 2'h0;
    chk(16'(comb_o[1:0]), 16'h3);
    pat = 16'hc5a3;
    wr_en = 2'h2;
    for (int i = 15; i >= 0; i--) begin
      wr_data = {~pat[i], pat[i], 2'h0};
      tick(1);
    end
    wr_en = 2'h0;
    lut_in = 16'h3000;
    #1;
    chk(16'(shift_o[3:2]), 16'({~pat[15], pat[15]}));
    chk(16'(comb_o[3:2]), 16'({~pat[3], pat[0]}));
    $display("test ram and shift done");
    lut_mode[1] = LTS_LUT_RAM;
    shape[0] = LTS_RAM_32X1;
    lut_init[31:0] = {16'h0000, 16'hffff};
    load();
    lut_in = 16'h0055; wr_en = 2'h1; wr_data = 4'h1; five_sel = 2'h1;
    tick(1);
    wr_data = 4'h0; five_sel = 2'h0;
    tick(1);
    wr_en = 2'h0; five_sel = 2'h1;
    #1;
    chk(16'(five_o[0]), 16'h1);
    five_sel = 2'h0;
    #1;
    chk(16'(five_o[0]), 16'h0);
    shape[0] = LTS_RAM_16X2; lut_in = 16'h0037; wr_en = 2'h1; wr_data = 4'h2;
    tick(1);
    wr_en = 2'h0;
    chk(16'(comb_o[1:0]), 16'h2);
    tick(1);
    shape[0] = LTS_RAM_DUAL; lut_in = 16'h0094; wr_en = 2'h1; wr_data = 4'h1;
    tick(1);
    wr_en = 2'h0;
    chk(16'(comb_o[1:0]), 16'h1);
    lut_in = 16'h0044;
    #1;
    chk(16'(comb_o[1:0]), 16'h3);
    tick(1);
    $display("test wide ram done");
    lut_mode = '{default: LTS_LUT_LOGIC}; shape[0] = LTS_RAM_SINGLE;
    lut_init[31:0] = {16'hfffe, 16'h8000};
    load();
    chk(16'(q_o), 16'h6);
    lut_in = 16'hffff; direct = 4'ha; ce = 2'h3;
    strobe(2'h3);
    chk(16'(q_o), 16'hb);
    ce = 2'h0; direct = 4'h0; lut_in = 16'h0;
    strobe(2'h3);
    chk(16'(q_o), 16'hb);
    init_f = 2'h3;
    tick(2);
    chk(16'(q_o), 16'hb);
    strobe(2'h3);
    chk(16'(q_o), 16'h6);
    init_f = 2'h0; opp_f = 2'h3;
    strobe(2'h3);
    chk(16'(q_o), 16'h9);
    init_f = 2'h3;
    strobe(2'h3);
    chk(16'(q_o), 16'h6);
    init_f = 2'h0; opp_f = 2'h0; inv_clk = 2'h3; inv_ce = 2'h3; direct = 4'hf; lut_in = 16'hffff;
    load();
    strobe(2'h3);
    chk(16'(q_o), 16'hf);
    inv_init = 2'h3;
    strobe(2'h3);
    chk(16'(q_o), 16'h6);
    inv_init = 2'h0; inv_opp = 2'h3;
    strobe(2'h3);
    chk(16'(q_o), 16'h9);
    inv_opp = 2'h0; dsel[0] = LTS_D_SUM; carry_in = 2'h1;
    strobe(2'h3);
    chk(16'(q_o), 16'he);
    dsel[0] = LTS_D_LUT; carry_in = 2'h0;
    inv_clk = 2'h0; inv_ce = 2'h0; ce = 2'h3; latch = 2'h1;
    load();
    fire = 2'h1; direct = 4'h1;
    tick(3);
    chk(16'(q_o), 16'h5);
    direct = 4'h0; lut_in = 16'h0;
    tick(3);
    chk(16'(q_o), 16'h4);
    fire = 2'h0;
    tick(2);
    direct = 4'h2; lut_in = 16'hffff;
    tick(3);
    chk(16'(q_o), 16'h4);
    latch = 2'h0; a_opp = 2'h2;
    load();
    opp_f = 2'h2;
    #1;
    chk(16'(q_o), 16'ha);
    opp_f = 2'h0;
    tick(1);
    $display("test storage done");
    rst_n_i = 1'b0;
    #1;
    chk({comb_o, q_o, shift_o, 4'h0}, 16'h0);
    tick(1);
    rst_n_i = 1'b1;
    tick(1);
    $display("test reset done");
    end_of_test();
  end
endmodule : lts_logic_tile_bench
`default_nettype wire
